// >>> rtl/pam_auto_mode_config.sv
// Purpose: Strap-selected operating mode, per-port register defaults and port control
//          for a four-port power-sourcing controller, reached over APB.
// Assumes: Inputs synchronous to pclk; strap code stable when reset is released.
// Notes:   Single-cycle APB slave; unmapped addresses answer with pslverr.
//
// What this block does
// - Signature good only when all four detection steps judged it good.
// - Port voltage and current registers refresh every three milliseconds.
// - Current measurement range switches dynamically when doubled limit is active.
// - Load removal turns a port off only with disconnect enabled.
// - Strong gate pull-down engages when current exceeds limit by 25 percent.
// - Each port's current limit selects 425 mA or 850 mA by programming.
// - Strap low selects host-controlled operation, not autonomous.
// - Reserved strap steps keep the device in shutdown.
// - Strap sampled once after each reset release; valid level loads its autonomous defaults.
// - Autonomous operation selected by strap or by host register write.
// - Strap at ground loads configuration 0x00, power 0x00, cut 0x54.
// - Class 3 levels loop detection, restart after 2 s, midspan or endpoint.
// - Class 4 levels behave like class 3 with power configuration 0x20.
// - Cut limit defaults to 0x54 in every mode.
// - Pin autonomous two-event class success sets high power and cut 0x62.
// - Pin autonomous modes load interrupt mask with 0xFF.
`timescale 1ns/1ps
module pam_auto_mode_config
    import pam_pkg::*;
#(
    parameter int unsigned MEAS_CYC    = MEAS_CYC_DEF,
    parameter int unsigned RESTART_CYC = RESTART_CYC_DEF
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic [7:0]           strap_code,
    input  wire pam_meas_t            meas_in [PORTS],
    input  wire pam_det_t             det_in,
    input  wire logic                 class_ok_valid,
    input  wire logic [1:0]           class_ok_port,
    input  wire logic [PORTS-1:0]     port_on_req,
    input  wire logic [PORTS-1:0]     load_removed,
    input  wire logic [PORTS-1:0]     port_fault,
    output logic      [PORTS-1:0]     port_power,
    output logic      [PORTS-1:0]     port_auto,
    output logic      [PORTS-1:0]     sig_good,
    output logic      [PORTS-1:0]     ilim_2x,
    output logic      [PORTS-1:0]     isense_range_hi,
    output logic      [PORTS-1:0]     gate_pulldown,
    output logic      [PORTS-1:0]     det_restart
);

    ////////////////////////////////////////////////////////////////////////////
    // Strap quantisation and profile decode.

    function automatic logic [3:0] strap_step(input logic [7:0] code);
        logic [15:0] scaled;
        scaled = 16'((int'(code) * (STRAP_STEPS - 1) + STRAP_FS / 2) / STRAP_FS);
        return scaled[3:0];
    endfunction : strap_step

    function automatic logic is_auto_step(input logic [3:0] s);
        return (s == STEP_C3_MID) || (s == STEP_C3_END) ||
               (s == STEP_C4_MID) || (s == STEP_C4_END);
    endfunction : is_auto_step

    function automatic logic [31:0] trip_limit(input logic two_x);
        return 32'((two_x ? ILIM_2X_MA : ILIM_1X_MA) * TRIP_PCT);
    endfunction : trip_limit

    pam_state_t state_q;
    pam_mode_t  mode_q;
    logic [3:0] step_q;
    logic       host_auto_q;
    logic [7:0] intmask_q;
    logic [7:0] conf_q [PORTS];
    logic [7:0] tlim_q [PORTS];
    logic [7:0] icut_q [PORTS];
    pam_meas_t  meas_q [PORTS];
    logic [PORTS-1:0] acc_q;
    logic [PORTS-1:0] sig_q;
    logic [PORTS-1:0] pwr_q;
    logic [PORTS-1:0] restart_q;
    logic [31:0] tick_cnt_q;
    logic [31:0] rst_cnt_q [PORTS];
    logic [31:0] prdata_q;

    wire logic [3:0] step_now  = strap_step(strap_code);
    wire logic       sampling  = (state_q == PAM_ST_SAMPLE);
    wire logic       pin_auto  = (mode_q == PAM_AUTO);
    wire logic       meas_tick = (tick_cnt_q == MEAS_CYC - 1);

    wire pam_mode_t  mode_now  = (step_now == STEP_GND) ? PAM_HOST :
                                 is_auto_step(step_now) ? PAM_AUTO : PAM_SHUT;
    // midspan steps load 0x7F, endpoint 0x3F
    wire logic       midspan   = (step_now == STEP_C3_MID) || (step_now == STEP_C4_MID);
    // class 4 steps load power config 0x20
    wire logic       class4    = (step_now == STEP_C4_MID) || (step_now == STEP_C4_END);
    wire logic [7:0] conf_def  = (mode_now != PAM_AUTO) ? CONF_SHUT :
                                 midspan ? CONF_MID : CONF_END;
    wire logic [7:0] tlim_def  = (mode_now == PAM_AUTO && class4) ? TLIM_CL4 : TLIM_CL3;

    ////////////////////////////////////////////////////////////////////////////
    // APB decode.

    wire logic       apb_setup = psel && !penable;
    wire logic       apb_wr    = psel && penable && pwrite;
    wire logic [2:0] blk       = paddr[6:4];
    wire logic       port_hit  = !paddr[7] && (blk != 3'd0) && (blk <= 3'(PORTS)) &&
                                 (paddr[1:0] == 2'b00);
    wire logic [1:0] psel_idx  = 2'(blk - 3'd1);
    wire logic [3:0] poff      = paddr[3:0];
    wire logic       glob_hit  = (paddr == REG_MODE) || (paddr == REG_CTRL) ||
                                 (paddr == REG_INTMASK) || (paddr == REG_STATUS);
    wire logic       mapped    = port_hit || glob_hit;
    wire logic       ro_hit    = (paddr == REG_MODE) || (paddr == REG_STATUS) ||
                                 (port_hit && poff == PREG_MEAS);

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (paddr == REG_MODE) begin
            rd_mux = {24'h00_0000, !sampling, 1'b0, mode_q, step_q};
        end else if (paddr == REG_CTRL) begin
            rd_mux = {31'h0000_0000, host_auto_q};
        end else if (paddr == REG_INTMASK) begin
            rd_mux = {24'h00_0000, intmask_q};
        end else if (paddr == REG_STATUS) begin
            rd_mux = {24'h00_0000, pwr_q, sig_q};
        end else if (port_hit) begin
            unique case (poff)
                PREG_CONF: rd_mux = {24'h00_0000, conf_q[psel_idx]};
                PREG_TLIM: rd_mux = {24'h00_0000, tlim_q[psel_idx]};
                PREG_ICUT: rd_mux = {24'h00_0000, icut_q[psel_idx]};
                PREG_MEAS: rd_mux = meas_q[psel_idx];
                default:   rd_mux = 32'h0000_0000;
            endcase
        end
    end

    assign pready  = 1'b1;
    assign pslverr = psel && penable && (!mapped || (pwrite && ro_hit));
    assign prdata  = prdata_q;

    // Read data is captured in the setup cycle so the access phase can finish at once.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (apb_setup) begin
            prdata_q <= mapped ? rd_mux : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Strap sampling and global registers.

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q     <= PAM_ST_SAMPLE;
            mode_q      <= PAM_SHUT;
            step_q      <= 4'h0;
            host_auto_q <= 1'b0;
            intmask_q   <= INTMASK_RST;
        end else begin
            unique case (state_q)
                PAM_ST_SAMPLE: begin
                    state_q   <= PAM_ST_RUN;
                    mode_q    <= mode_now;
                    step_q    <= step_now;
                    intmask_q <= (mode_now == PAM_AUTO) ? INTMASK_AUTO : INTMASK_RST;
                end
                PAM_ST_RUN: begin
                    if (apb_wr && paddr == REG_CTRL) begin
                        host_auto_q <= pwdata[0];
                    end
                    if (apb_wr && paddr == REG_INTMASK) begin
                        intmask_q <= pwdata[7:0];
                    end
                end
                default: state_q <= PAM_ST_SAMPLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Measurement cadence.

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_q <= 32'h0000_0000;
        end else begin
            tick_cnt_q <= meas_tick ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-port configuration, detection, power and restart.

    for (genvar p = 0; p < PORTS; p++) begin : g_port
        wire logic wr_here  = apb_wr && port_hit && (psel_idx == 2'(p)) && !sampling;
        wire logic hi_pwr   = class_ok_valid && (class_ok_port == 2'(p)) && pin_auto;
        wire logic det_here = det_in.valid && (det_in.port == 2'(p));
        wire logic restart_now;
        assign port_auto[p] = !sampling && (mode_q != PAM_SHUT) &&
                              (pin_auto || host_auto_q || conf_q[p][1:0] == CONF_AUTO_FLD);
        assign ilim_2x[p] = tlim_q[p][TLIM_HPEN_BIT];
        assign isense_range_hi[p] = ilim_2x[p] &&
                                    (32'(meas_in[p].curr_ma) > 32'(ILIM_1X_MA));
        // trip at 125 percent of limit
        assign gate_pulldown[p] = pwr_q[p] &&
                                  (32'(meas_in[p].curr_ma) * PCT_FULL > trip_limit(ilim_2x[p]));
        assign restart_now = port_auto[p] && !pwr_q[p] && (rst_cnt_q[p] == RESTART_CYC - 1);

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                conf_q[p] <= CONF_SHUT;
                tlim_q[p] <= TLIM_CL3;
                icut_q[p] <= ICUT_DEF;
            end else if (sampling) begin
                conf_q[p] <= conf_def;
                tlim_q[p] <= tlim_def;
                icut_q[p] <= ICUT_DEF;
            end else begin
                if (wr_here && poff == PREG_CONF) begin
                    conf_q[p] <= pwdata[7:0];
                end
                // Hardware raise wins over a host write in the same cycle.
                if (hi_pwr) begin
                    tlim_q[p] <= tlim_q[p] | (8'h01 << TLIM_HPEN_BIT);
                    icut_q[p] <= ICUT_HIPWR;
                end else begin
                    if (wr_here && poff == PREG_TLIM) begin
                        tlim_q[p] <= pwdata[7:0];
                    end
                    if (wr_here && poff == PREG_ICUT) begin
                        icut_q[p] <= pwdata[7:0];
                    end
                end
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                meas_q[p]    <= '0;
                acc_q[p]     <= 1'b0;
                sig_q[p]     <= 1'b0;
                pwr_q[p]     <= 1'b0;
                rst_cnt_q[p] <= 32'h0000_0000;
                restart_q[p] <= 1'b0;
            end else begin
                if (meas_tick) begin
                    meas_q[p] <= meas_in[p];
                end
                if (det_here) begin
                    acc_q[p] <= (det_in.step == 2'd0) ? det_in.ok : (acc_q[p] && det_in.ok);
                    if (det_in.step == 2'(DET_STEPS - 1)) begin
                        sig_q[p] <= acc_q[p] && det_in.ok;
                    end
                end
                if (port_fault[p] || mode_q == PAM_SHUT || sampling ||
                    (load_removed[p] && conf_q[p][CONF_DCDIS_BIT])) begin
                    pwr_q[p] <= 1'b0;
                end else if (port_on_req[p]) begin
                    pwr_q[p] <= 1'b1;
                end
                if (!port_auto[p] || pwr_q[p] || restart_now) begin
                    rst_cnt_q[p] <= 32'h0000_0000;
                end else begin
                    rst_cnt_q[p] <= rst_cnt_q[p] + 32'h0000_0001;
                end
                restart_q[p] <= restart_now;
            end
        end
    end

    assign port_power  = pwr_q;
    assign sig_good    = sig_q;
    assign det_restart = restart_q;

endmodule : pam_auto_mode_config

// >>> rtl/pam_pkg.sv
// Purpose: Shared constants and types for the per-port mode and configuration loader.
// Assumes: 25 MHz pclk, four ports, 32-bit APB register access.
// Notes:   Currents are in mA and strap levels are in 8-bit converter codes.
package pam_pkg;
    localparam int unsigned PORTS         = 4;
    localparam int unsigned CLK_HZ        = 25_000_000;
    localparam int unsigned MEAS_PERIOD_US = 3000;
    localparam int unsigned RESTART_S     = 2;
    localparam int unsigned MEAS_CYC_DEF  = MEAS_PERIOD_US * (CLK_HZ / 1_000_000);
    localparam int unsigned RESTART_CYC_DEF = RESTART_S * CLK_HZ;

    // Register byte offsets; per-port blocks start at 0x10, one 16-byte block per port.
    localparam logic [7:0] REG_MODE    = 8'h00;
    localparam logic [7:0] REG_CTRL    = 8'h04;
    localparam logic [7:0] REG_INTMASK = 8'h08;
    localparam logic [7:0] REG_STATUS  = 8'h0C;
    localparam logic [3:0] PREG_CONF   = 4'h0;
    localparam logic [3:0] PREG_TLIM   = 4'h4;
    localparam logic [3:0] PREG_ICUT   = 4'h8;
    localparam logic [3:0] PREG_MEAS   = 4'hC;

    // Configuration defaults and field positions.
    localparam logic [7:0] CONF_SHUT   = 8'h00;
    localparam logic [7:0] CONF_MID    = 8'h7F;
    localparam logic [7:0] CONF_END    = 8'h3F;
    localparam logic [7:0] TLIM_CL3    = 8'h00;
    localparam logic [7:0] TLIM_CL4    = 8'h20;
    localparam logic [7:0] ICUT_DEF    = 8'h54;
    localparam logic [7:0] ICUT_HIPWR  = 8'h62;
    localparam logic [7:0] INTMASK_AUTO = 8'hFF;
    localparam logic [7:0] INTMASK_RST = 8'h00;
    localparam int unsigned TLIM_HPEN_BIT = 7;
    localparam int unsigned CONF_DCDIS_BIT = 5;
    localparam logic [1:0] CONF_AUTO_FLD = 2'b11;

    // Strap quantisation: sixteen even steps over the full converter code range.
    localparam int unsigned STRAP_STEPS = 16;
    localparam int unsigned STRAP_FS    = 255;
    localparam logic [3:0] STEP_GND     = 4'h0;
    localparam logic [3:0] STEP_C3_MID  = 4'h3;
    localparam logic [3:0] STEP_C3_END  = 4'h7;
    localparam logic [3:0] STEP_C4_MID  = 4'hB;
    localparam logic [3:0] STEP_C4_END  = 4'hF;

    // Current limits and transient trip ratio in percent.
    localparam int unsigned ILIM_1X_MA  = 425;
    localparam int unsigned ILIM_2X_MA  = 850;
    localparam int unsigned TRIP_PCT    = 125;
    localparam int unsigned PCT_FULL    = 100;
    localparam int unsigned DET_STEPS   = 4;

    typedef enum logic [1:0] {
        PAM_HOST = 2'b00,
        PAM_SHUT = 2'b01,
        PAM_AUTO = 2'b10
    } pam_mode_t;

    typedef enum logic [1:0] {
        PAM_ST_SAMPLE = 2'b00,
        PAM_ST_RUN    = 2'b01
    } pam_state_t;

    typedef struct packed {
        logic [15:0] volt_mv;
        logic [15:0] curr_ma;
    } pam_meas_t;

    typedef struct packed {
        logic       valid;
        logic [1:0] port;
        logic [1:0] step;
        logic       ok;
    } pam_det_t;
endpackage : pam_pkg

// >>> tb/pam_pd_model.sv
// Purpose: Powered devices on the four ports: loads, detection and class events.
// Assumes: Called from the bench; every change lands right after a pclk edge.
// Notes:   Idle detection fields carry noise so that only valid qualifies them.
`timescale 1ns/1ps
module pam_pd_model
    import pam_pkg::*;
(
    input  wire logic        pclk,
    output pam_meas_t        meas [PORTS],
    output pam_det_t         det,
    output logic             cls_v,
    output logic [1:0]       cls_p,
    output logic [PORTS-1:0] gone
);
    initial begin
        meas  = '{default: '0};
        det   = '0;
        cls_v = 1'b0;
        cls_p = 2'h0;
        gone  = '0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // four signature steps
    task automatic detect(input logic [1:0] p, input logic [3:0] okm);
        for (int s = 0; s < DET_STEPS; s++) begin
            @(posedge pclk);
            det <= '{valid: 1'b1, port: p, step: 2'(s), ok: okm[s]};
        end
        @(posedge pclk);
        det <= pam_det_t'({1'b0, 5'($urandom)});
    endtask : detect
    task automatic classify(input logic [1:0] p);
        @(posedge pclk);
        cls_v <= 1'b1;
        cls_p <= p;
        @(posedge pclk);
        cls_v <= 1'b0;
        cls_p <= 2'($urandom);
    endtask : classify
    task automatic load(input int p, input int mv, input int ma, input logic rm);
        @(posedge pclk);
        meas[p] <= '{volt_mv: 16'(mv), curr_ma: 16'(ma)};
        gone[p] <= rm;
    endtask : load
endmodule : pam_pd_model

// >>> tb/pam_chk.sv
// Purpose: Port-level assertions for the strap mode loader.
// Assumes: One pclk domain; strap code steady when reset is released.
// Notes:   Restart timing is watched on port 0 only, to keep helpers small.
`timescale 1ns/1ps
module pam_chk
    import pam_pkg::*;
#(
    parameter int unsigned RESTART_CYC = RESTART_CYC_DEF
) (
    input wire logic             pclk,
    input wire logic             presetn,
    input wire logic [7:0]       strap_code,
    input wire pam_det_t         det_in,
    input wire logic             class_ok_valid,
    input wire logic [1:0]       class_ok_port,
    input wire logic [PORTS-1:0] port_fault,
    input wire logic [PORTS-1:0] port_power,
    input wire logic [PORTS-1:0] port_auto,
    input wire logic [PORTS-1:0] sig_good,
    input wire logic [PORTS-1:0] ilim_2x,
    input wire logic [PORTS-1:0] isense_range_hi,
    input wire logic [PORTS-1:0] gate_pulldown,
    input wire logic [PORTS-1:0] det_restart
);
    logic             samp_q;
    logic             auto_q;
    logic             resv_q;
    logic [PORTS-1:0] acc_q;
    int unsigned      idle_q;
    logic [3:0]       stp_w;
    logic             sg_exp_w;
    assign stp_w    = 4'((16'(strap_code) * 16'd15 + 16'd127) / 16'd255);
    assign sg_exp_w = acc_q[det_in.port] & det_in.ok;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            samp_q <= 1'b0;
            auto_q <= 1'b0;
            resv_q <= 1'b0;
        end else if (!samp_q) begin
            samp_q <= 1'b1;
            auto_q <= stp_w[1:0] == 2'b11;
            resv_q <= stp_w != 4'h0 && stp_w[1:0] != 2'b11;
        end
    end
    // Step 0 starts a fresh judgement, so stale results never leak in.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q <= '0;
        end else if (det_in.valid) begin
            acc_q[det_in.port] <= det_in.ok & (det_in.step == 2'd0 | acc_q[det_in.port]);
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_q <= 0;
        end else if (port_auto[0] && !port_power[0] && !det_restart[0]) begin
            idle_q <= idle_q + 1;
        end else begin
            idle_q <= 0;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    chk_sig_update: assert property (
        det_in.valid && det_in.step == 2'd3 |=> sig_good[$past(det_in.port)] == $past(sg_exp_w))
        else $error("signature flag wrong");
    chk_pulldown_pwr: assert property ((gate_pulldown & ~port_power) == '0)
        else $error("pull-down on unpowered port");
    chk_range_lim: assert property ((isense_range_hi & ~ilim_2x) == '0)
        else $error("high range without doubled limit");
    chk_class_hipwr: assert property (
        samp_q && auto_q && class_ok_valid |=> ilim_2x[$past(class_ok_port)])
        else $error("class success did not raise limit");
    chk_fault_off: assert property (|port_fault |=> (port_power & $past(port_fault)) == '0)
        else $error("faulted port still powered");
    chk_resv_shut: assert property (resv_q |-> port_power == '0)
        else $error("port powered in shutdown");
    chk_pin_auto: assert property (samp_q && auto_q |-> port_auto == 4'hF)
        else $error("pin autonomous not on all ports");
    chk_restart_win: assert property (
        det_restart[0] |-> idle_q + 2 >= RESTART_CYC && idle_q <= RESTART_CYC + 2)
        else $error("restart pulse off its period");
    cov_restart: cover property (det_restart[0]);
    cov_trip: cover property (gate_pulldown != '0);
    cov_class: cover property (class_ok_valid && auto_q);
endmodule : pam_chk
bind pam_auto_mode_config pam_chk #(.RESTART_CYC(RESTART_CYC)) chk_u (
    .pclk, .presetn, .strap_code, .det_in, .class_ok_valid, .class_ok_port, .port_fault,
    .port_power, .port_auto, .sig_good, .ilim_2x, .isense_range_hi, .gate_pulldown,
    .det_restart);

// >>> tb/tb.sv
// Purpose: Self-checking bench for the strap mode loader and port control.
// Assumes: pclk 25 MHz; the partner model supplies loads and port events.
// Notes:   Measurement and restart counts are shortened through parameters.
`timescale 1ns/1ps
module tb
    import pam_pkg::*;
;
    localparam int unsigned MC = 8;
    localparam int unsigned RC = 16;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, cls_v;
    logic [7:0]  paddr, strap_code;
    logic [31:0] pwdata, prdata;
    logic [1:0]  cls_p;
    logic [3:0]  on_req, fault, gone, pwr, auto, sg, lim2, rhi, pdn, rsp;
    pam_meas_t   meas [PORTS];
    pam_det_t    det;
    int          num_errors, n_checks, cyc;
    pam_auto_mode_config #(.MEAS_CYC(MC), .RESTART_CYC(RC)) dut_u (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .strap_code, .meas_in(meas), .det_in(det), .class_ok_valid(cls_v),
        .class_ok_port(cls_p), .port_on_req(on_req), .port_fault(fault),
        .load_removed(gone), .port_power(pwr), .port_auto(auto), .sig_good(sg),
        .ilim_2x(lim2), .isense_range_hi(rhi), .gate_pulldown(pdn), .det_restart(rsp));
    pam_pd_model pd_u (.pclk, .meas, .det, .cls_v, .cls_p, .gone);
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // The whole run needs about 600 cycles; the ceiling leaves ample margin.
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            num_errors++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic cmp(input logic [31:0] got, input logic [31:0] x);
        n_checks++;
        if (got !== x) begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, x);
        end
    endtask : cmp
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        // The bench ceiling ends this wait if pready never rises, so a stuck slave reaches the verdict.
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        cmp(r, x);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
        cmp({31'h0, e}, 32'h0);
    endtask : wr
    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask : settle
    task automatic pulse_on(input logic [3:0] m);
        @(posedge pclk);
        on_req <= m;
        @(posedge pclk);
        on_req <= 4'h0;
    endtask : pulse_on
    task automatic rst(input logic [7:0] code);
        @(posedge pclk);
        presetn    <= 1'b0;
        strap_code <= code;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
    endtask : rst
    function automatic logic [7:0] pa(input int p, input logic [3:0] o);
        return 8'(16 * (p + 1)) + {4'h0, o};
    endfunction : pa
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        int          k, md, p, mv;
        logic        au, hit, e;
        logic [31:0] r;
        logic [5:0]  m;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata, strap_code, on_req, fault} = '0;
        void'($urandom(32'h8BEE7E36));
        for (int s = 0; s < STRAP_STEPS; s++) begin
            k  = s * 17 + int'($urandom_range(16)) - 8;
            rst(8'(k < 0 ? 0 : (k > 255 ? 255 : k)));
            au = s % 4 == 3;
            md = s == 0 ? 0 : (au ? 2 : 1);
            p  = $urandom_range(3);
            rd(REG_MODE, {24'h0, 2'b10, 2'(md), 4'(s)});
            rd(pa(p, PREG_ICUT), 32'h54);
            rd(REG_INTMASK, au ? 32'hFF : 32'h0);
            if (md != 1) rd(pa(p, PREG_CONF), md == 0 ? 32'h0 : (s[2] ? 32'h3F : 32'h7F));
            if (md != 1) rd(pa(p, PREG_TLIM), s[3] ? 32'h20 : 32'h0);
            pulse_on(4'hF);
            settle(1);
            cmp({28'h0, pwr}, md == 1 ? 32'h0 : 32'hF);
            $display("strap step %0d done", s);
        end
        rst(8'hFF);
        mv = $urandom_range(65535);
        pd_u.load(1, mv, 500, 1'b0);
        settle(2 * MC);
        rd(pa(1, PREG_MEAS), {16'(mv), 16'd500});
        pd_u.classify(2'd1);
        rd(pa(1, PREG_TLIM), 32'hA0);
        rd(pa(1, PREG_ICUT), 32'h62);
        settle(0);
        cmp({28'h0, lim2}, 32'h2);
        cmp({28'h0, rhi}, 32'h2);
        hit = 1'b0;
        for (k = 0; k < 3 * RC; k++) begin
            @(negedge pclk);
            hit = hit | rsp[0];
        end
        cmp({31'h0, hit}, 32'h1);
        pulse_on(4'h2);
        for (k = 0; k < 2; k++) begin
            pd_u.load(1, mv, 1062 + k, 1'b0);
            settle(2 * MC);
            cmp({28'h0, pdn}, 32'(2 * k));
        end
        pd_u.load(1, mv, 0, 1'b1);
        settle(2);
        cmp({28'h0, pwr}, 32'h0);
        $display("pin autonomous test done");
        rst(8'h00);
        @(posedge pclk);
        strap_code <= 8'hFF;
        rd(REG_MODE, 32'h80);
        wr(pa(2, PREG_CONF), 32'h23);
        wr(pa(3, PREG_CONF), 32'h03);
        settle(0);
        cmp({28'h0, auto}, 32'hC);
        wr(REG_CTRL, 32'h1);
        settle(0);
        cmp({28'h0, auto}, 32'hF);
        wr(REG_CTRL, 32'h0);
        pulse_on(4'hC);
        pd_u.load(2, 0, 0, 1'b1);
        pd_u.load(3, 0, 0, 1'b1);
        settle(2);
        cmp({28'h0, pwr}, 32'h8);
        @(posedge pclk);
        fault <= 4'h8;
        settle(2);
        cmp({28'h0, pwr}, 32'h0);
        @(posedge pclk);
        fault <= 4'h0;
        pd_u.classify(2'd2);
        rd(pa(2, PREG_ICUT), 32'h54);
        wr(pa(0, PREG_TLIM), 32'h80);
        settle(0);
        cmp({28'h0, lim2}, 32'h1);
        apb(1'b0, 8'h50, 32'h0, r, e);
        cmp({31'h0, e}, 32'h1);
        apb(1'b1, REG_MODE, 32'h0F, r, e);
        cmp({31'h0, e}, 32'h1);
        rd(REG_MODE, 32'h80);
        for (k = 0; k < 6; k++) begin
            m = k == 0 ? 6'h0F : 6'($urandom);
            pd_u.detect(m[5:4], m[3:0]);
            settle(0);
            cmp({31'h0, sg[m[5:4]]}, {31'h0, &m[3:0]});
        end
        $display("host mode test done");
        finish_test();
    end
endmodule : tb
